// *** rtl/sac_pkg.sv ***
// package: register map, mode field layout and conversion timing for the SAR converter control
// What this block does
// - comparator settles 1 us before valid result
// - run and comparator enable give four states
// - range 00 divider picks 352..44 clock lengths
// - range 01 divider picks 480..80 clock lengths
// - result word low six bits read zero
// - high byte address holds upper eight bits
// - result word 16-bit read, reset 0000H
// - high byte register holds top eight, reset 00H
// - mode/channel/pin writes may spoil results
// - result reads insert one wait cycle
// - mode register writes insert one wait cycle
// - continuous conversion, done pulse each result
// - approximation resolves MSB first, then transfers
package sac_pkg;
  localparam logic [15:0] SAC_ADDR_RES_WORD = 16'hFF06;
  localparam logic [15:0] SAC_ADDR_RES_HIGH = 16'hFF07;
  localparam logic [15:0] SAC_ADDR_MODE = 16'hFF08;
  localparam logic [15:0] SAC_ADDR_CHAN = 16'hFF09;
  localparam logic [15:0] SAC_ADDR_PINCFG = 16'hFF8F;
  localparam logic [7:0] SAC_MODE_RST = 8'h00;
  localparam logic [15:0] SAC_RES_WORD_RST = 16'h0000;
  localparam logic [7:0] SAC_RES_HIGH_RST = 8'h00;
  localparam int SAC_BIT_RUN = 7;
  localparam int SAC_FR_HI = 6;
  localparam int SAC_FR_LO = 3;
  localparam int SAC_LV_HI = 2;
  localparam int SAC_LV_LO = 1;
  localparam int SAC_BIT_CMPEN = 0;
  localparam int SAC_RES_BITS = 10;
  localparam int SAC_RES_PAD = 6;
  localparam int SAC_CLK_MHZ = 100;
  localparam int SAC_SETTLE_US = 1;
  localparam int SAC_SETTLE_CYC = SAC_SETTLE_US * SAC_CLK_MHZ;
  localparam int SAC_LEN_W = 10;
  // total length in converter clocks: 22 at range 00, 40 at range 01
  localparam int SAC_CONV_SLOTS = 22;
  localparam int SAC_SAMPLE_SLOTS = SAC_CONV_SLOTS - SAC_RES_BITS;
  localparam int SAC_CONV_SLOTS_LOW = 40;
endpackage : sac_pkg

// *** rtl/sac_sar.sv ***
`timescale 1ns/1ps
// module: approximation shift register, MSB first
module sac_sar
  import sac_pkg::*;
#(
  parameter int W = SAC_RES_BITS
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic start_i,
  input wire logic step_i,
  input wire logic cmp_i,
  // state
  output logic [W-1:0] trial_o,
  output logic [W-1:0] value_o
);
  logic [W-1:0] val_ff;
  logic [W-1:0] bit_ff;
  wire [W-1:0] nxt_val = start_i ? {1'b1, {(W-1){1'b0}}} :
    (step_i ? ((cmp_i ? val_ff : (val_ff & ~bit_ff)) | (bit_ff >> 1)) : val_ff);
  wire [W-1:0] nxt_bit = start_i ? {1'b1, {(W-1){1'b0}}} : (step_i ? (bit_ff >> 1) : bit_ff);
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      val_ff <= '0;
      bit_ff <= '0;
    end else begin
      val_ff <= nxt_val;
      bit_ff <= nxt_bit;
    end
  end
  assign trial_o = val_ff;
  // final decided value including current comparison
  assign value_o = cmp_i ? val_ff : (val_ff & ~bit_ff);
endmodule : sac_sar

// *** rtl/sac_ctrl.sv ***
`timescale 1ns/1ps
// module: SAR converter control with mode register and result registers
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int SETTLE_CYC = SAC_SETTLE_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // cpu memory access
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic wide_i,
  input wire logic [7:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic wait_o,
  // analog front end
  input wire logic cmp_result_i,
  output logic comparator_en_o,
  output logic sample_o,
  output logic [SAC_RES_BITS-1:0] dac_code_o,
  // status
  output logic conversion_done_irq_o,
  output logic converting_o,
  output logic first_invalid_o,
  output logic waiting_o
);
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_CONVERT = 3'b100
  } sac_state_e;

  function automatic logic [4:0] div_of(input logic [3:0] fr, input logic [1:0] lv);
    logic [4:0] d;
    d = 5'h00;
    if (lv == 2'b00 && fr[3]) d = 5'h10;
    else if (lv[1] == 1'b0 && !fr[3]) begin
      unique case (fr[2:0])
        3'h0: d = 5'h0C;
        3'h1: d = 5'h08;
        3'h2: d = 5'h06;
        3'h3: d = 5'h04;
        3'h4: d = 5'h03;
        3'h5: d = 5'h02;
        default: d = 5'h00;
      endcase
    end
    return d;
  endfunction : div_of

  logic [7:0] mode_ff;
  logic [15:0] res_word_ff;
  logic [7:0] res_high_ff;
  sac_state_e st_ff;
  logic [4:0] pre_ff;
  logic [5:0] slot_ff;
  logic [7:0] settle_ff;
  logic first_bad_ff;
  logic done_ff;
  logic wait_ff;
  logic [15:0] rdata_ff;
  logic sample_ff;
  logic [SAC_RES_BITS-1:0] dac_ff;

  wire run = mode_ff[SAC_BIT_RUN];
  wire cmp_en = mode_ff[SAC_BIT_CMPEN];
  wire [3:0] fr = mode_ff[SAC_FR_HI:SAC_FR_LO];
  wire [1:0] lv = mode_ff[SAC_LV_HI:SAC_LV_LO];
  // same divider at both ranges, but fr[3] set is legal at range 00 only; the low range stretches sampling to 30 slots (40 in total)
  wire [4:0] div = div_of(fr, lv);
  wire legal = (div != 5'h00);
  wire [5:0] slots = (lv == 2'b01) ? 6'(SAC_CONV_SLOTS_LOW) : 6'(SAC_CONV_SLOTS);
  wire [5:0] sample_last = slots - 6'(SAC_RES_BITS + 1);
  wire tick = (pre_ff == 5'(div - 5'h01));
  wire last_slot = (slot_ff == 6'(slots - 6'h01));
  wire mode_wr = wr_i && (addr_i == SAC_ADDR_MODE);
  // results are kept as they are; software reads them before such writes
  wire cfg_wr = wr_i && (addr_i == SAC_ADDR_CHAN || addr_i == SAC_ADDR_PINCFG);
  wire rd_word = rd_i && wide_i && (addr_i == SAC_ADDR_RES_WORD);
  wire rd_high = rd_i && !wide_i && (addr_i == SAC_ADDR_RES_HIGH);
  wire rd_mode = rd_i && !wide_i && (addr_i == SAC_ADDR_MODE);
  wire start = run && legal && (st_ff == SAC_IDLE);
  wire step = (st_ff == SAC_CONVERT) && tick;
  wire finish = step && last_slot;
  wire [SAC_RES_BITS-1:0] trial;
  wire [SAC_RES_BITS-1:0] decided;
  wire cmp_ok = (settle_ff == 8'(SETTLE_CYC));
  wire sar_load = (st_ff == SAC_SAMPLE) && tick && (slot_ff == sample_last);

  sac_sar #(.W(SAC_RES_BITS)) u_sar (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(sar_load),
    .step_i(step && !last_slot),
    .cmp_i(cmp_result_i),
    .trial_o(trial),
    .value_o(decided)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode_ff <= SAC_MODE_RST;
    end else if (mode_wr) begin
      mode_ff <= wdata_i;
    end
  end

  // settle counter restarts whenever the comparator is off
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !cmp_en) begin
      settle_ff <= 8'h00;
    end else if (!cmp_ok) begin
      settle_ff <= settle_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !run) begin
      st_ff <= SAC_IDLE;
      pre_ff <= 5'h00;
      slot_ff <= 6'h00;
    end else begin
      pre_ff <= (tick || st_ff == SAC_IDLE) ? 5'h00 : 5'(pre_ff + 5'h01);
      unique case (st_ff)
        SAC_IDLE: begin
          if (start) st_ff <= SAC_SAMPLE;
          slot_ff <= 6'h00;
        end
        SAC_SAMPLE: begin
          if (tick) begin
            slot_ff <= 6'(slot_ff + 6'h01);
            if (slot_ff == sample_last) st_ff <= SAC_CONVERT;
          end
        end
        SAC_CONVERT: begin
          if (tick) begin
            // no stop after the last slot: repeat from sampling
            slot_ff <= last_slot ? 6'h00 : 6'(slot_ff + 6'h01);
            if (last_slot) st_ff <= SAC_SAMPLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      res_word_ff <= SAC_RES_WORD_RST;
      res_high_ff <= SAC_RES_HIGH_RST;
      first_bad_ff <= 1'b0;
    end else begin
      if (finish) begin
        res_word_ff <= {decided, {SAC_RES_PAD{1'b0}}};
        res_high_ff <= decided[SAC_RES_BITS-1 -: 8];
      end
      // first result after a start is suspect unless comparator already settled
      if (start) first_bad_ff <= !cmp_ok;
      else if (finish) first_bad_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      done_ff <= 1'b0;
      wait_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      sample_ff <= 1'b0;
      dac_ff <= '0;
    end else begin
      done_ff <= finish;
      // reads of results and writes of setup registers stretch by one cycle
      wait_ff <= rd_word || rd_high || mode_wr || cfg_wr;
      rdata_ff <= rd_word ? res_word_ff :
        (rd_high ? {8'h00, res_high_ff} : (rd_mode ? {8'h00, mode_ff} : 16'h0000));
      sample_ff <= (st_ff == SAC_SAMPLE);
      dac_ff <= trial;
    end
  end

  assign rdata_o = rdata_ff;
  assign wait_o = wait_ff;
  assign comparator_en_o = mode_ff[SAC_BIT_CMPEN];
  assign sample_o = sample_ff;
  assign dac_code_o = dac_ff;
  assign conversion_done_irq_o = done_ff;
  assign converting_o = (st_ff != SAC_IDLE);
  assign first_invalid_o = first_bad_ff;
  assign waiting_o = !run && cmp_en;
endmodule : sac_ctrl

// *** test/sac_front_model.sv ***
// analog front end model: comparator against a held input level
`timescale 1ns/1ps
module sac_front_model (
  input wire logic mclk_i,
  input wire logic comparator_en_i,
  input wire logic [9:0] dac_code_i,
  input wire logic [9:0] level_i,
  output logic cmp_result_o
);
  logic junk_ff = 1'b0;
  // a stopped comparator gives noise, not a stale answer
  always @(posedge mclk_i) junk_ff <= ~junk_ff;
  // keep bit when input >= trial, msb first
  assign cmp_result_o = comparator_en_i ? (level_i >= dac_code_i) : junk_ff;
endmodule : sac_front_model

// *** test/sac_ctrl_checker.sv ***
// checker on the converter control ports
`timescale 1ns/1ps
module sac_ctrl_checker
  import sac_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic wide_i,
  input wire logic [7:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic wait_o,
  input wire logic comparator_en_o,
  input wire logic sample_o,
  input wire logic conversion_done_irq_o,
  input wire logic converting_o,
  input wire logic waiting_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire res_rd = rd_i && ((wide_i && addr_i == SAC_ADDR_RES_WORD) ||
    (!wide_i && addr_i == SAC_ADDR_RES_HIGH));
  chk_read_wait: assert property (res_rd |=> wait_o) else $error("no read wait");
  chk_mode_wait: assert property (wr_i && addr_i == SAC_ADDR_MODE |=> wait_o)
    else $error("no mode write wait");
  chk_low_zero: assert property (rd_i && wide_i && addr_i == SAC_ADDR_RES_WORD
    |=> rdata_o[5:0] == 6'h00) else $error("low result bits set");
  chk_idle_rdata: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data without read");
  chk_cmp_follow: assert property (wr_i && addr_i == SAC_ADDR_MODE
    |=> comparator_en_o == $past(wdata_i[SAC_BIT_CMPEN])) else $error("comparator enable");
  chk_wait_state: assert property (waiting_o |-> comparator_en_o ##1 !converting_o)
    else $error("waiting without comparator");
  chk_done_pulse: assert property (conversion_done_irq_o |=> !conversion_done_irq_o)
    else $error("done longer than a cycle");
  // sample flag is registered, so it trails the state by one cycle
  chk_sample_conv: assert property (sample_o |-> $past(converting_o))
    else $error("sampling while idle");
  cov_done: cover property (conversion_done_irq_o);
  cov_wait: cover property (waiting_o);
  cov_rd: cover property (res_rd);
endmodule : sac_ctrl_checker

// *** test/sac_ctrl_tb.sv ***
// testbench for the converter control block
`timescale 1ns/1ps
module sac_ctrl_tb;
  import sac_pkg::*;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0, wide_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic [9:0] level = 10'h2D5;
  logic [15:0] rdata_o, d;
  logic wait_o, cmp_result_i, comparator_en_o, sample_o, conversion_done_irq_o;
  logic converting_o, first_invalid_o, waiting_o;
  logic [9:0] dac_code_o;
  int num_errors = 0, n_tests = 0, cyc = 0, n;
  always #5 mclk_i = ~mclk_i;
  sac_ctrl #(.SETTLE_CYC(4)) i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .rd_i(rd_i), .wr_i(wr_i), .wide_i(wide_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .wait_o(wait_o), .cmp_result_i(cmp_result_i), .comparator_en_o(comparator_en_o),
    .sample_o(sample_o), .dac_code_o(dac_code_o), .conversion_done_irq_o(conversion_done_irq_o),
    .converting_o(converting_o), .first_invalid_o(first_invalid_o), .waiting_o(waiting_o));
  sac_front_model i_fe (.mclk_i(mclk_i), .comparator_en_i(comparator_en_o),
    .dac_code_i(dac_code_o), .level_i(level), .cmp_result_o(cmp_result_i));
  task summarize;
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : check
  task acc(input logic [15:0] a, input logic w, input logic r, input logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wide_i <= w;
    rd_i <= r;
    wr_i <= !r;
    wdata_i <= v;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    #1 d = rdata_o;
  endtask : acc
  // cycles until the next done pulse, bounded
  task wdone;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1 n++;
    end while (conversion_done_irq_o !== 1'b1 && n < 1000);
  endtask : wdone
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    acc(SAC_ADDR_RES_WORD, 1'b1, 1'b1, 8'h00); check("word rst", SAC_RES_WORD_RST, d);
    acc(SAC_ADDR_RES_HIGH, 1'b0, 1'b1, 8'h00); check("high rst", 16'h0000, d);
    acc(16'hFF00, 1'b1, 1'b1, 8'h00); check("unmapped", 16'h0000, d);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'h01); check("waiting", 16'h0001, waiting_o);
    repeat (8) @(posedge mclk_i);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'hA9);
    @(posedge mclk_i);
    #1 check("settled", 16'h0000, first_invalid_o);
    wdone(); wdone(); check("len 44", 16'd44, 16'(n));
    acc(SAC_ADDR_RES_WORD, 1'b1, 1'b1, 8'h00); check("word", {level, 6'h00}, d);
    acc(SAC_ADDR_RES_HIGH, 1'b0, 1'b1, 8'h00); check("high", {8'h00, level[9:2]}, d);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'h01);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'hAB);
    wdone(); wdone(); check("len 80", 16'd80, 16'(n));
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'h01);
    level = 10'h133;
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'hA9);
    repeat (20) @(posedge mclk_i);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'h01);
    wdone(); check("abort", 16'd1000, 16'(n));
    acc(SAC_ADDR_RES_WORD, 1'b1, 1'b1, 8'h00); check("kept", {10'h2D5, 6'h00}, d);
    // real-time window cannot be met at the fast sim clock; lengths are checked in clocks
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'hC1);
    wdone(); wdone(); check("len 352", 16'd352, 16'(n));
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'h01);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'h85);
    repeat (4) @(posedge mclk_i);
    #1 check("illegal", 16'h0000, converting_o);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'h00);
    acc(SAC_ADDR_MODE, 1'b0, 1'b0, 8'hA9);
    @(posedge mclk_i);
    #1 check("first bad", 16'h0001, first_invalid_o);
    wdone(); check("first ok", 16'h0000, first_invalid_o);
    summarize();
  end
endmodule : sac_ctrl_tb
bind sac_ctrl sac_ctrl_checker i_chk (.*);
